// [src/hbfm_regs.svh]
`ifndef HBFM_REGS_SVH
`define HBFM_REGS_SVH
// Contract
// - select bit 13 clear: overcurrent latches driver off after 200 us
// - select bit 13 set: overcurrent latches driver off after 25 us
// - underload shutdown clear: underload sets status only, drivers unchanged
// - underload shutdown set: driver latched off after 350 us underload
// - output current limiting always enabled regardless of bit 13
// - latched faults and latched-off drivers cleared only by valid reset frame
// - overvoltage sets supply fail; lockout bit 15 picks drivers on or off
// - overvoltage supply fail clears only below hysteresis plus status reset
// - undervoltage sets supply fail, all outputs off until supply returns
// - thermal shutdown turns drivers off, programmed state kept
// - thermal shutdown has no status bit of its own; apb status bit 16 reads it live
// - thermal warning bit 0 latches, stays after cooling, drivers stay on
// - input bit 0 is the status reset request
// - underload status on output bit 14 after underload delay

// clock and fault timing
`define HBFM_PCLK_NS         40
`define HBFM_T_OC_LONG_NS    200000
`define HBFM_T_OC_SHORT_NS   25000
`define HBFM_T_UL_NS         350000
`define HBFM_FRAME_BITS      16

// serial frame fields
`define HBFM_IN_SRR          0
`define HBFM_IN_HS_LSB       1
`define HBFM_IN_LS_LSB       7
`define HBFM_IN_OCD          13
`define HBFM_IN_ULD          14
`define HBFM_IN_OVERVOLTAGE_LOCKOUT_ENABLE         15
`define HBFM_OUT_TW          0
`define HBFM_OUT_LATCH_LSB   1
`define HBFM_OUT_OCF         13
`define HBFM_OUT_ULD         14
`define HBFM_OUT_PSF         15

// apb register offsets
`define HBFM_STATUS_OFS      8'h00
`define HBFM_CONFIG_OFS      8'h04
`define HBFM_INT_STAT_OFS    8'h08
`define HBFM_INT_CLR_OFS     8'h0C
`define HBFM_INT_EN_OFS      8'h10
`define HBFM_CONFIG_RST      16'h0000
`define HBFM_INT_EN_RST      6'h00

`endif

// [src/hbfm_pkg.sv]
package hbfm_pkg;
  localparam int NCH   = 6;
  localparam int CNT_W = 14;
  localparam int SYN_W = 20;

  // interrupt event positions
  typedef enum logic [2:0] {
    HBFM_EV_TW   = 3'b000,
    HBFM_EV_PSF  = 3'b001,
    HBFM_EV_ULD  = 3'b010,
    HBFM_EV_OC   = 3'b011,
    HBFM_EV_TSD  = 3'b100,
    HBFM_EV_FRM  = 3'b101
  } hbfm_ev_e;

  // whole state of the fault manager
  typedef struct packed {
    logic [SYN_W-1:0]            sy1;
    logic [SYN_W-1:0]            sy2;
    logic                        sclk_d;
    logic                        csn_d;
    logic                        tsd_d;
    logic [15:0]                 rx_sh;
    logic [15:0]                 tx_sh;
    logic [4:0]                  bit_cnt;
    logic [15:0]                 cfg;
    logic [NCH-1:0][CNT_W-1:0]   oc_cnt;
    logic [CNT_W-1:0]            ul_cnt;
    logic [NCH-1:0]              off_latch;
    logic                        tw_flag;
    logic                        psf_flag;
    logic                        psf_ov;
    logic                        uld_flag;
    logic                        ocf_flag;
    logic [NCH-1:0]              hs_drv;
    logic [NCH-1:0]              ls_drv;
    logic                        miso;
    logic                        miso_oe;
    logic                        cur_lim;
    logic                        irq;
    logic [5:0]                  int_stat;
    logic [5:0]                  int_en;
    logic [31:0]                 prdata;
    logic                        pready;
    logic                        pslverr;
  } hbfm_state_s;
endpackage : hbfm_pkg

// [src/hbfm_fault_mgr.sv]
// The APB interface to the registers and the address map were left to the implementer.
`include "hbfm_regs.svh"

module hbfm_fault_mgr
  import hbfm_pkg::*;
#(
  parameter int OC_LONG_CYC  =
    (`HBFM_T_OC_LONG_NS + `HBFM_PCLK_NS - 1) / `HBFM_PCLK_NS,
  parameter int OC_SHORT_CYC =
    (`HBFM_T_OC_SHORT_NS + `HBFM_PCLK_NS - 1) / `HBFM_PCLK_NS,
  parameter int UL_CYC       =
    (`HBFM_T_UL_NS + `HBFM_PCLK_NS - 1) / `HBFM_PCLK_NS
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             ce,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic             spi_sclk,
  input  wire logic             spi_csn,
  input  wire logic             spi_mosi,
  output logic                  spi_miso,
  output logic                  spi_miso_oe,
  input  wire logic [NCH-1:0]   oc_det,
  input  wire logic [NCH-1:0]   ul_det,
  input  wire logic             ov_det,
  input  wire logic             ov_below_hyst,
  input  wire logic             uv_det,
  input  wire logic             tw_det,
  input  wire logic             tsd_det,
  output logic      [NCH-1:0]   hs_drv,
  output logic      [NCH-1:0]   ls_drv,
  output logic                  cur_limit_en,
  output logic                  irq
);

  localparam int I_SCLK = 0;
  localparam int I_CSN  = 1;
  localparam int I_MOSI = 2;
  localparam int I_OC   = 3;
  localparam int I_UL   = 9;
  localparam int I_OV   = 15;
  localparam int I_HYS  = 16;
  localparam int I_UV   = 17;
  localparam int I_TW   = 18;
  localparam int I_TSD  = 19;

  hbfm_state_s      s;
  hbfm_state_s      n;
  logic [SYN_W-1:0] raw;
  logic [NCH-1:0]   oc_in;
  logic [NCH-1:0]   ul_in;
  logic [NCH-1:0]   ch_on;
  logic [NCH-1:0]   ul_hit_mask;
  logic             frame_end;
  logic             frame_ok;
  logic             status_reset_request;
  logic             ul_hit;
  logic             allow;
  logic             apb_acc;
  logic [5:0]       ev;
  logic [CNT_W-1:0] oc_lim;
  logic [15:0]      out_word;

  //////////////////////////////////////////////////////////////////////////
  // pin gathering and decoded views of the synchronised inputs
  assign raw = {tsd_det, tw_det, uv_det, ov_below_hyst, ov_det, ul_det,
                oc_det, spi_mosi, spi_csn, spi_sclk};
  assign oc_in     = s.sy2[I_OC +: NCH];
  assign ul_in     = s.sy2[I_UL +: NCH];
  assign ch_on     = s.hs_drv | s.ls_drv;
  assign frame_end = s.sy2[I_CSN] && !s.csn_d;
  assign frame_ok  = frame_end && (s.bit_cnt == 5'(`HBFM_FRAME_BITS));
  assign status_reset_request       = frame_ok && s.rx_sh[`HBFM_IN_SRR];
  assign apb_acc   = psel && penable;

  // status word shifted out, thermal warning first
  assign out_word = {s.psf_flag, s.uld_flag, s.ocf_flag,
                     6'h00, s.off_latch, s.tw_flag};

  // register address decode that sets pslverr on unmapped reads and writes
  function automatic logic hbfm_mapped(input logic [7:0] a);
    hbfm_mapped = (a == `HBFM_STATUS_OFS) || (a == `HBFM_CONFIG_OFS) ||
                  (a == `HBFM_INT_STAT_OFS) || (a == `HBFM_INT_CLR_OFS) ||
                  (a == `HBFM_INT_EN_OFS);
  endfunction : hbfm_mapped

  //////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    n           = s;
    ev          = 6'h00;
    ul_hit      = 1'b0;
    ul_hit_mask = '0;
    allow       = 1'b0;
    oc_lim      = s.cfg[`HBFM_IN_OCD] ? CNT_W'(OC_SHORT_CYC)
                                      : CNT_W'(OC_LONG_CYC);

    // two-stage synchronisers and edge history
    n.sy1    = raw;
    n.sy2    = s.sy1;
    n.sclk_d = s.sy2[I_SCLK];
    n.csn_d  = s.sy2[I_CSN];
    n.tsd_d  = s.sy2[I_TSD];

    // serial frame, lsb first, shift in on rise, shift out on fall
    if (!s.sy2[I_CSN] && s.csn_d) begin
      n.bit_cnt = 5'h00;
      n.tx_sh   = out_word;
    end else if (!s.sy2[I_CSN]) begin
      if (s.sy2[I_SCLK] && !s.sclk_d) begin
        n.rx_sh = {s.sy2[I_MOSI], s.rx_sh[15:1]};
        if (s.bit_cnt != 5'h1F) begin
          n.bit_cnt = s.bit_cnt + 5'h01;
        end
      end
      if (!s.sy2[I_SCLK] && s.sclk_d) begin
        n.tx_sh = {1'b0, s.tx_sh[15:1]};
      end
    end
    n.miso    = n.tx_sh[0];
    n.miso_oe = !s.sy2[I_CSN];

    // a valid frame programs the drivers; bad frames change nothing
    if (frame_ok) begin
      n.cfg = s.rx_sh;
      ev[HBFM_EV_FRM] = 1'b1;
    end

    // status reset, applied before new faults so a set wins
    if (status_reset_request) begin
      n.off_latch = '0;
      n.tw_flag   = 1'b0;
      n.uld_flag  = 1'b0;
      n.ocf_flag  = 1'b0;
      if (!s.psf_ov || s.sy2[I_HYS]) begin
        n.psf_flag = 1'b0;
        n.psf_ov   = 1'b0;
      end
    end

    // per-channel overcurrent timers
    for (int k = 0; k < NCH; k++) begin
      if (oc_in[k] && ch_on[k] && !s.off_latch[k]) begin
        if (s.oc_cnt[k] >= oc_lim - CNT_W'(1)) begin
          n.off_latch[k]  = 1'b1;
          n.ocf_flag      = 1'b1;
          n.oc_cnt[k]     = '0;
          ev[HBFM_EV_OC]  = 1'b1;
        end else begin
          n.oc_cnt[k] = s.oc_cnt[k] + CNT_W'(1);
        end
      end else if (!oc_in[k]) begin
        n.oc_cnt[k] = '0;
      end
    end

    // one global underload timer shared by all channels
    if (|(ul_in & ch_on & ~s.off_latch)) begin
      if (s.ul_cnt >= CNT_W'(UL_CYC) - CNT_W'(1)) begin
        ul_hit      = 1'b1;
        ul_hit_mask = ul_in & ch_on;
        n.ul_cnt    = '0;
      end else begin
        n.ul_cnt = s.ul_cnt + CNT_W'(1);
      end
    end else begin
      n.ul_cnt = '0;
    end
    if (ul_hit) begin
      n.uld_flag      = 1'b1;
      ev[HBFM_EV_ULD] = 1'b1;
      if (s.cfg[`HBFM_IN_ULD]) begin
        n.off_latch = n.off_latch | ul_hit_mask;
      end
    end

    // supply fail from either over- or undervoltage
    if (s.sy2[I_OV]) begin
      n.psf_flag = 1'b1;
      n.psf_ov   = 1'b1;
    end
    if (s.sy2[I_UV]) begin
      n.psf_flag = 1'b1;
    end
    ev[HBFM_EV_PSF] = n.psf_flag && !s.psf_flag;

    // thermal warning latches; shutdown not latched, reported as an event and live in apb status bit 16
    if (s.sy2[I_TW]) begin
      n.tw_flag = 1'b1;
    end
    ev[HBFM_EV_TW]  = n.tw_flag && !s.tw_flag;
    ev[HBFM_EV_TSD] = s.sy2[I_TSD] && !s.tsd_d;

    // driver gating from the synchronised supply and thermal state
    allow = !s.sy2[I_UV]
         && !(s.sy2[I_OV] && n.cfg[`HBFM_IN_OVERVOLTAGE_LOCKOUT_ENABLE])
         && !s.sy2[I_TSD];
    n.hs_drv  = n.cfg[`HBFM_IN_HS_LSB +: NCH] & ~n.off_latch & {NCH{allow}};
    n.ls_drv  = n.cfg[`HBFM_IN_LS_LSB +: NCH] & ~n.off_latch & {NCH{allow}};
    n.cur_lim = 1'b1;

    // apb slave, one wait state, write lands with pready
    n.pready  = 1'b0;
    n.pslverr = 1'b0;
    if (apb_acc && !s.pready) begin
      n.pready  = 1'b1;
      n.pslverr = !hbfm_mapped(paddr);
      n.prdata  = 32'h0000_0000;
      case (paddr)
        `HBFM_STATUS_OFS: begin
          n.prdata = {13'h0000, s.sy2[I_OV], s.sy2[I_UV], s.sy2[I_TSD],
                      out_word};
        end
        `HBFM_CONFIG_OFS: begin
          n.prdata = {16'h0000, s.cfg};
        end
        `HBFM_INT_STAT_OFS: begin
          n.prdata = {26'h0000000, s.int_stat};
        end
        `HBFM_INT_EN_OFS: begin
          n.prdata = {26'h0000000, s.int_en};
        end
        default: begin
          n.prdata = 32'h0000_0000;
        end
      endcase
    end
    if (apb_acc && s.pready && pwrite) begin
      if (paddr == `HBFM_INT_CLR_OFS) begin
        n.int_stat = s.int_stat & ~pwdata[5:0];
      end
      if (paddr == `HBFM_INT_EN_OFS) begin
        n.int_en = pwdata[5:0];
      end
    end

    // sticky events win over a clear in the same cycle
    n.int_stat = n.int_stat | ev;
    n.irq      = |(n.int_stat & n.int_en);
  end

  //////////////////////////////////////////////////////////////////////////
  // state register with clock enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s         <= '0;
      s.sy1     <= {{(SYN_W-2){1'b0}}, 2'b10};
      s.sy2     <= {{(SYN_W-2){1'b0}}, 2'b10};
      s.csn_d   <= 1'b1;
      s.cfg     <= `HBFM_CONFIG_RST;
      s.int_en  <= `HBFM_INT_EN_RST;
      s.cur_lim <= 1'b1;
    end else if (ce) begin
      s <= n;
    end
  end

  // outputs straight from the state register
  assign prdata       = s.prdata;
  assign pready       = s.pready;
  assign pslverr      = s.pslverr;
  assign spi_miso     = s.miso;
  assign spi_miso_oe  = s.miso_oe;
  assign hs_drv       = s.hs_drv;
  assign ls_drv       = s.ls_drv;
  assign cur_limit_en = s.cur_lim;
  assign irq          = s.irq;

  //////////////////////////////////////////////////////////////////////////
  // checks
  localparam int OCS = OC_SHORT_CYC;
  localparam int OCL = OC_LONG_CYC;

  sequence s_oc_last(int lim);
    ce && oc_in[0] && ch_on[0] && !s.off_latch[0] && !status_reset_request
       && s.oc_cnt[0] == CNT_W'(lim - 1);
  endsequence

  property p_oc_short;
    @(posedge pclk) disable iff (!presetn)
    s.cfg[`HBFM_IN_OCD] and s_oc_last(OCS) |=> s.off_latch[0] && !s.hs_drv[0];
  endproperty
  a_oc_short: assert property (p_oc_short)
    else $error("short overcurrent did not latch off");

  property p_oc_long;
    @(posedge pclk) disable iff (!presetn)
    !s.cfg[`HBFM_IN_OCD] and s_oc_last(OCL) |=> s.off_latch[0] && s.ocf_flag;
  endproperty
  a_oc_long: assert property (p_oc_long)
    else $error("long overcurrent did not latch off");

  property p_latched_off;
    @(posedge pclk) disable iff (!presetn)
    ((s.hs_drv | s.ls_drv) & s.off_latch) == '0;
  endproperty
  a_latched_off: assert property (p_latched_off)
    else $error("latched-off channel still driven");

  property p_ul_status_only;
    @(posedge pclk) disable iff (!presetn)
    ce && ul_hit && !s.cfg[`HBFM_IN_ULD] && !status_reset_request && oc_in == '0
      |=> s.uld_flag && $stable(s.off_latch);
  endproperty
  a_ul_status_only: assert property (p_ul_status_only)
    else $error("underload without shutdown changed drivers");

  property p_cur_lim;
    @(posedge pclk) disable iff (!presetn)
    cur_limit_en;
  endproperty
  a_cur_lim: assert property (p_cur_lim)
    else $error("current limit disabled");

  property p_srr_clear;
    @(posedge pclk) disable iff (!presetn)
    ce && status_reset_request && !s.sy2[I_TW] && oc_in == '0 && !ul_hit
      |=> !s.tw_flag && s.off_latch == '0;
  endproperty
  a_srr_clear: assert property (p_srr_clear)
    else $error("status reset did not clear");

  property p_bad_frame;
    @(posedge pclk) disable iff (!presetn)
    ce && frame_end && !frame_ok |=> $stable(s.cfg);
  endproperty
  a_bad_frame: assert property (p_bad_frame)
    else $error("invalid frame changed configuration");

  property p_supply_off;
    @(posedge pclk) disable iff (!presetn)
    ce && !frame_ok && (s.sy2[I_UV] || s.sy2[I_TSD]
      || (s.sy2[I_OV] && s.cfg[`HBFM_IN_OVERVOLTAGE_LOCKOUT_ENABLE]))
      |=> s.hs_drv == '0 && s.ls_drv == '0;
  endproperty
  a_supply_off: assert property (p_supply_off)
    else $error("drivers on during lockout or shutdown");

  property p_psf_hold;
    @(posedge pclk) disable iff (!presetn)
    ce && s.psf_flag && s.psf_ov && !s.sy2[I_HYS] |=> s.psf_flag;
  endproperty
  a_psf_hold: assert property (p_psf_hold)
    else $error("supply fail cleared above hysteresis");

  property p_tw_latch;
    @(posedge pclk) disable iff (!presetn)
    ce && s.sy2[I_TW] |=> s.tw_flag ##1 (s.tw_flag || $past(status_reset_request));
  endproperty
  a_tw_latch: assert property (p_tw_latch)
    else $error("thermal warning not latched");

endmodule : hbfm_fault_mgr

// [verification/hbfm_spi_master.sv]
////////////////////////////////////////////////////////////////////////
// serial master in front of the fault manager
module hbfm_spi_master (
  input  wire logic spi_miso,
  output logic      spi_sclk,
  output logic      spi_csn,
  output logic      spi_mosi
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HALF = 160;

  // idle: clock parked low, deselected
  initial begin
    spi_sclk = 1'b0;
    spi_csn  = 1'b1;
    spi_mosi = 1'b0;
  end

  // one frame, lsb first; fewer than 16 clocks gives a bad frame
  task automatic xfer(input logic [15:0] tx, input int nbits,
                      output logic [15:0] rx);
    rx = 16'h0000;
    #7 spi_csn = 1'b0;
    #HALF;
    for (int i = 0; i < nbits; i++) begin
      spi_mosi = tx[i];
      #HALF spi_sclk = 1'b1;
      #(HALF - 1) rx[i] = spi_miso;
      #1 spi_sclk = 1'b0;
    end
    #HALF spi_csn = 1'b1;
    spi_mosi = ~spi_mosi; // released line shows no stale level
  endtask : xfer
endmodule : hbfm_spi_master

// [verification/test_half_bridge_fault_manager.sv]
`include "hbfm_regs.svh"
`define HBFM_CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
  bad_count++; $display("Error at %0t: got %0h expected %0h", \
  $time, g, e); end end

module test_half_bridge_fault_manager
  import hbfm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic           pclk = 1'b0;
  logic           presetn = 1'b0;
  logic           ce = 1'b1;
  logic           psel = 1'b0;
  logic           penable = 1'b0;
  logic           pwrite = 1'b0;
  logic [7:0]     paddr = 8'h00;
  logic [31:0]    pwdata = 32'h0;
  logic [31:0]    prdata;
  logic           pready;
  logic           pslverr;
  logic           spi_sclk;
  logic           spi_csn;
  logic           spi_mosi;
  logic           spi_miso;
  logic           spi_miso_oe;
  logic [NCH-1:0] oc_det = '0;
  logic [NCH-1:0] ul_det = '0;
  logic           ov_det = 1'b0;
  logic           ov_below_hyst = 1'b0;
  logic           uv_det = 1'b0;
  logic           tw_det = 1'b0;
  logic           tsd_det = 1'b0;
  logic [NCH-1:0] hs_drv;
  logic [NCH-1:0] ls_drv;
  logic           cur_limit_en;
  logic           irq;
  logic [31:0]    rdata;
  logic           perr;
  logic [15:0]    rx;
  logic [15:0]    cfg = 16'h0102;
  int             bad_count = 0;
  int             checks_done = 0;

  ////////////////////////////////////////////////////////////////////
  // clock and instances
  always #20 pclk = ~pclk;

  hbfm_fault_mgr #(.OC_LONG_CYC(20), .OC_SHORT_CYC(5), .UL_CYC(30))
    u_hbfm_fault_mgr (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .spi_sclk(spi_sclk), .spi_csn(spi_csn),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe), .oc_det(oc_det), .ul_det(ul_det),
    .ov_det(ov_det), .ov_below_hyst(ov_below_hyst), .uv_det(uv_det),
    .tw_det(tw_det), .tsd_det(tsd_det), .hs_drv(hs_drv),
    .ls_drv(ls_drv), .cur_limit_en(cur_limit_en), .irq(irq));

  hbfm_spi_master u_hbfm_spi_master (.spi_miso(spi_miso),
    .spi_sclk(spi_sclk), .spi_csn(spi_csn), .spi_mosi(spi_mosi));

  ////////////////////////////////////////////////////////////////////
  // bus and link tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      $display("Error at %0t: bus answer missing", $time);
    end
    rdata = prdata;
    perr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic frame(input logic [15:0] w, input int n = 16);
    u_hbfm_spi_master.xfer(w, n, rx);
    cyc(12);
  endtask : frame

  task automatic print_verdict;
    $display("Mismatches %0d, checks %0d", bad_count, checks_done);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict

  ////////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    #2_000_000;
    bad_count++;
    print_verdict();
  end

  ////////////////////////////////////////////////////////////////////
  // test sequence
  initial begin
    cyc(6);
    presetn <= 1'b1;
    cyc(4);
    `HBFM_CHK(cur_limit_en, 1'b1)
    `HBFM_CHK({spi_miso_oe, irq}, 2'b00)
    apb(1'b0, 8'h40, 32'h0);
    `HBFM_CHK({perr, rdata}, 33'h100000000)
    apb(1'b1, `HBFM_INT_EN_OFS, 32'h3F);
    frame(cfg, 15);
    `HBFM_CHK({hs_drv, ls_drv}, 12'h000)
    frame(cfg);
    `HBFM_CHK({hs_drv, ls_drv}, 12'h042)
    // overcurrent, long then short delay
    for (int k = 0; k < 2; k++) begin
      frame(cfg | (16'(k) << 13));
      oc_det <= 6'h01;
      cyc(k ? 3 : 18);
      `HBFM_CHK(hs_drv, 6'h01)
      cyc(12);
      oc_det <= 6'h00;
      cyc(5);
      `HBFM_CHK(hs_drv, 6'h00)
      `HBFM_CHK({cur_limit_en, irq}, 2'b11)
      apb(1'b0, `HBFM_STATUS_OFS, 32'h0);
      `HBFM_CHK(rdata[15:0], 16'h2002)
      frame(cfg | 16'h0001 | (16'(k) << 13), 15);
      `HBFM_CHK(hs_drv, 6'h00)
      frame(cfg | 16'h0001 | (16'(k) << 13));
      `HBFM_CHK(hs_drv, 6'h01)
      apb(1'b0, `HBFM_STATUS_OFS, 32'h0);
      `HBFM_CHK(rdata[15:0], 16'h0000)
    end
    // underload, status only then shutdown
    for (int k = 0; k < 2; k++) begin
      frame(cfg | (16'(k) << 14));
      ul_det <= 6'h02;
      cyc(25);
      `HBFM_CHK(ls_drv, 6'h02)
      cyc(15);
      ul_det <= 6'h00;
      cyc(5);
      `HBFM_CHK(ls_drv, k ? 6'h00 : 6'h02)
      apb(1'b0, `HBFM_STATUS_OFS, 32'h0);
      `HBFM_CHK(rdata[15:0], k ? 16'h4004 : 16'h4000)
      frame(cfg | 16'h0001 | (16'(k) << 14));
      `HBFM_CHK(ls_drv, 6'h02)
    end
    // overvoltage with and without lockout
    for (int k = 0; k < 2; k++) begin
      frame(cfg | (16'(k) << 15));
      ov_det <= 1'b1;
      cyc(5);
      `HBFM_CHK({hs_drv, ls_drv}, k ? 12'h000 : 12'h042)
      ov_det <= 1'b0;
      cyc(5);
      `HBFM_CHK({hs_drv, ls_drv}, 12'h042)
      frame(cfg | 16'h0001 | (16'(k) << 15));
      apb(1'b0, `HBFM_STATUS_OFS, 32'h0);
      `HBFM_CHK(rdata[15], 1'b1)
      ov_below_hyst <= 1'b1;
      frame(cfg | 16'h0001 | (16'(k) << 15));
      ov_below_hyst <= 1'b0;
      apb(1'b0, `HBFM_STATUS_OFS, 32'h0);
      `HBFM_CHK(rdata[15], 1'b0)
    end
    // undervoltage
    uv_det <= 1'b1;
    cyc(5);
    `HBFM_CHK({hs_drv, ls_drv}, 12'h000)
    uv_det <= 1'b0;
    cyc(5);
    `HBFM_CHK({hs_drv, ls_drv}, 12'h042)
    apb(1'b0, `HBFM_STATUS_OFS, 32'h0);
    `HBFM_CHK(rdata[15], 1'b1)
    frame(cfg | 16'h0001);
    apb(1'b0, `HBFM_STATUS_OFS, 32'h0);
    `HBFM_CHK(rdata[15], 1'b0)
    // thermal shutdown and warning
    tsd_det <= 1'b1;
    cyc(5);
    `HBFM_CHK({hs_drv, ls_drv}, 12'h000)
    tsd_det <= 1'b0;
    cyc(5);
    `HBFM_CHK({hs_drv, ls_drv}, 12'h042)
    apb(1'b0, `HBFM_STATUS_OFS, 32'h0);
    `HBFM_CHK(rdata[15:0], 16'h0000)
    apb(1'b0, `HBFM_CONFIG_OFS, 32'h0);
    `HBFM_CHK(rdata, 32'h00000103)
    tw_det <= 1'b1;
    cyc(5);
    tw_det <= 1'b0;
    cyc(5);
    `HBFM_CHK({hs_drv, ls_drv}, 12'h042)
    frame(cfg);
    `HBFM_CHK(rx[0], 1'b1)
    frame(cfg | 16'h0001);
    apb(1'b0, `HBFM_STATUS_OFS, 32'h0);
    `HBFM_CHK(rdata[0], 1'b0)
    // interrupt mask and clear
    apb(1'b0, `HBFM_INT_STAT_OFS, 32'h0);
    `HBFM_CHK({irq, rdata[5:0]}, 7'h7F)
    apb(1'b1, `HBFM_INT_EN_OFS, 32'h0);
    cyc(2);
    `HBFM_CHK(irq, 1'b0)
    apb(1'b1, `HBFM_INT_EN_OFS, 32'h3F);
    apb(1'b1, `HBFM_INT_CLR_OFS, 32'h3F);
    apb(1'b0, `HBFM_INT_STAT_OFS, 32'h0);
    `HBFM_CHK({irq, rdata[5:0]}, 7'h00)
    print_verdict();
  end
endmodule : test_half_bridge_fault_manager
